// File: bench/adcc_analog_model.sv
// analog front end and trigger sources facing the control block
`timescale 1ns/10ps
module adcc_analog_model (
  input wire logic [5:0] chan_sel,
  input wire logic chan_valid,
  input wire logic [8:0] trig_req,
  output logic [9:0] conv_data,
  output logic [8:0] trig_lines
);
  // sample depends on the code; an unselected input shows a junk pattern
  assign conv_data = chan_valid ? {4'h5, chan_sel} : 10'h2aa;
  // trigger sources are plain levels, raised by the bench
  assign trig_lines = trig_req;
endmodule : adcc_analog_model

// File: bench/adcc_ctrl_tb.sv
// self-checking bench for the converter control register block
`timescale 1ns/10ps
module adcc_ctrl_tb;
  localparam logic [9:0] RES = adcc_pkg::IDX_RESULT;
  localparam logic [9:0] C0 = adcc_pkg::IDX_CTRL0;
  localparam logic [9:0] C1 = adcc_pkg::IDX_CTRL1;
  localparam logic [9:0] TRG = adcc_pkg::IDX_TRIG;
  localparam logic [9:0] STS = adcc_pkg::IDX_IRQ_STATUS;
  localparam logic [9:0] MSK = adcc_pkg::IDX_IRQ_MASK;
  localparam int TADS = 2;
  localparam int RCD = 4;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [11:0] wb_adr = 12'h000;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0;
  logic [8:0] trig = 9'h000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [9:0] conv_data;
  logic [8:0] trl;
  logic analog_on_o, hold_o, chan_valid_o, ref_valid_o, irq_o;
  logic [5:0] chan_sel_o;
  logic [1:0] ref_sel_o;
  int bad_count = 0;
  int check_count = 0;
  int i;
  int n;
  logic [31:0] x;

  // short counts keep each conversion to two conversion clock periods, at most 128 cycles
  adcc_ctrl #(.CONV_TADS(TADS), .RC_DIV(RCD)) uut (
    .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .conv_data_i(conv_data), .trig_pin_remap(trl[0]),
    .timer_zero_rollover(trl[1]), .timer_one_rollover(trl[2]),
    .timer_two_divided_output(trl[3]),
    .capture_compare_one_event(trl[4]),
    .capture_compare_two_event(trl[5]),
    .pulse_width_three_output(trl[6]), .pulse_width_four_output(trl[7]),
    .pin_change_flag(trl[8]), .analog_on_o(analog_on_o), .hold_o(hold_o),
    .chan_sel_o(chan_sel_o), .chan_valid_o(chan_valid_o),
    .ref_sel_o(ref_sel_o), .ref_valid_o(ref_valid_o), .irq_o(irq_o)
  );

  adcc_analog_model far (
    .chan_sel(chan_sel_o), .chan_valid(chan_valid_o), .trig_req(trig),
    .conv_data(conv_data), .trig_lines(trl)
  );

  // free-running system clock
  always #5 clk_sys = ~clk_sys;

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic we, input logic [9:0] idx,
      input logic [3:0] sel, input logic [31:0] wd, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge clk_sys);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {idx, 2'b00};
    wb_sel <= sel;
    wb_dat <= wd;
    do begin
      @(posedge clk_sys);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o;
    if (k == 20) bad_count++;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask : wb

  task automatic wr(input logic [9:0] idx, input logic [3:0] sel,
      input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, idx, sel, d, r);
  endtask : wr

  task automatic rc(input logic [9:0] idx, input logic [3:0] sel,
      input logic [31:0] exp);
    logic [31:0] r;
    wb(1'b0, idx, sel, 32'h0, r);
    chk(r, exp);
  endtask : rc

  // polls the sticky done flag; the read that finds it also clears it
  task automatic wait_done;
    logic [31:0] r;
    int k;
    k = 0;
    do begin
      wb(1'b0, STS, 4'h1, 32'h0, r);
      k++;
    end while (r[0] !== 1'b1 && k < 40);
    chk({31'h0, r[0]}, 32'h1);
  endtask : wait_done

  // hold stays high for one whole conversion at clock code cs
  task automatic conv_len(input logic [2:0] cs, input int exp);
    int k;
    int m;
    k = 0;
    m = 0;
    wr(C1, 4'h1, {24'h0, 1'b1, cs, 4'h0});
    wr(C0, 4'h1, {24'h0, 6'h1b, 2'b11});
    while (hold_o !== 1'b1 && k < 20) begin
      @(posedge clk_sys);
      k++;
    end
    while (hold_o === 1'b1 && m < 300) begin
      @(posedge clk_sys);
      m++;
    end
    wait_done();
    chk(m, exp);
  endtask : conv_len

  task automatic pulse(input logic [8:0] v);
    @(posedge clk_sys);
    trig <= v;
    @(posedge clk_sys);
    trig <= 9'h000;
  endtask : pulse

  function automatic logic chan_ok(input int c);
    return c <= 2 || c == 4 || c == 5 || (c >= 13 && c <= 15) ||
      (c >= 18 && c <= 21) || c == 27 || c == 30;
  endfunction : chan_ok

  // bound on the whole run, far above what the sequence needs
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    finish_test();
  end

  // main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rc(RES, 4'h3, 32'h0);
    rc(C0, 4'h1, 32'h0);
    rc(C1, 4'h1, 32'h0);
    rc(TRG, 4'h1, 32'h0);
    rc(10'h0c0, 4'hf, 32'h0);
    for (i = 0; i < 64; i++) begin
      wr(C0, 4'h1, 32'({i[5:0], 2'b01}));
      rc(C0, 4'h1, 32'({i[5:0], 2'b01}));
      chk({31'h0, chan_valid_o}, {31'h0, chan_ok(i)});
      chk({26'h0, chan_sel_o}, 32'(i[5:0]));
    end
    for (i = 0; i < 16; i++) begin
      wr(C1, 4'h1, 32'({i[3], i[2:0], 2'b00, i[1:0]}));
      rc(C1, 4'h1, 32'({i[3], i[2:0], 2'b00, i[1:0]}));
      chk({31'h0, ref_valid_o}, {31'h0, i[1:0] != 2'b01});
      chk({30'h0, ref_sel_o}, 32'(i[1:0]));
    end
    // start request while disabled does nothing
    wr(C0, 4'h1, {24'h0, 6'h1b, 2'b10});
    @(posedge clk_sys);
    chk({31'h0, analog_on_o}, 32'h0);
    rc(C0, 4'h1, {24'h0, 6'h1b, 2'b00});
    rc(STS, 4'h1, 32'h0);
    // right-justified conversion with the interrupt unmasked
    wr(C1, 4'h1, 32'h80);
    wr(MSK, 4'h1, 32'h1);
    wr(C0, 4'h1, {24'h0, 6'h1b, 2'b01});
    @(posedge clk_sys);
    chk({31'h0, analog_on_o}, 32'h1);
    repeat (8) @(posedge clk_sys);
    wr(C0, 4'h1, {24'h0, 6'h1b, 2'b11});
    n = 0;
    while (irq_o !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    chk({31'h0, irq_o}, 32'h1);
    rc(C0, 4'h1, {24'h0, 6'h1b, 2'b01});
    rc(RES, 4'h3, {22'h0, 4'h5, 6'h1b});
    wr(MSK, 4'h1, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq_o}, 32'h0);
    wr(MSK, 4'h1, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq_o}, 32'h1);
    rc(STS, 4'h1, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq_o}, 32'h0);
    rc(STS, 4'h1, 32'h0);
    // left-justified conversion
    wr(C1, 4'h1, 32'h00);
    wr(C0, 4'h1, {24'h0, 6'h1b, 2'b11});
    wait_done();
    rc(RES, 4'h3, {16'h0, 4'h5, 6'h1b, 6'h00});
    // written result is stored raw, byte lanes independent
    wr(RES, 4'h3, 32'h0123);
    rc(RES, 4'h3, 32'h0123);
    wr(RES, 4'h2, 32'hab00);
    rc(RES, 4'h3, 32'hab23);
    // every trigger source starts a conversion on its rising edge
    for (i = 1; i < 10; i++) begin
      wr(TRG, 4'h1, 32'(i));
      pulse(9'(1 << (i - 1)));
      wait_done();
    end
    // reserved trigger codes give no start at all
    for (i = 10; i < 16; i++) begin
      if (i != 13) begin
        wr(TRG, 4'h1, 32'(i));
        pulse(9'h1ff);
        rc(C0, 4'h1, {24'h0, 6'h1b, 2'b01});
        rc(STS, 4'h1, 32'h0);
        rc(TRG, 4'h1, 32'(i));
      end
    end
    // reading the high result byte starts a conversion
    // a low byte read must not trigger, the high byte read must
    wr(TRG, 4'h1, 32'hd);
    rc(RES, 4'h1, {16'h0, 4'h5, 6'h1b, 6'h00});
    rc(C0, 4'h1, {24'h0, 6'h1b, 2'b01});
    wb(1'b0, RES, 4'h2, 32'h0, x);
    chk(x, {16'h0, 4'h5, 6'h1b, 6'h00});
    wait_done();
    wr(TRG, 4'h1, 32'h0);
    // conversion length follows each clock code
    conv_len(3'h0, TADS * 2);
    conv_len(3'h1, TADS * 8);
    conv_len(3'h2, TADS * 32);
    conv_len(3'h3, TADS * RCD);
    conv_len(3'h4, TADS * 4);
    conv_len(3'h5, TADS * 16);
    conv_len(3'h6, TADS * 64);
    conv_len(3'h7, TADS * RCD);
    finish_test();
  end
endmodule : adcc_ctrl_tb

// File: design/adcc_ctrl.sv
// converter control, result and interrupt registers on a wishbone slave
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/10ps
module adcc_ctrl #(
  parameter int CONV_TADS = 11,
  parameter int RC_DIV = 100
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [9:0] conv_data_i,
  input wire logic trig_pin_remap,
  input wire logic timer_zero_rollover,
  input wire logic timer_one_rollover,
  input wire logic timer_two_divided_output,
  input wire logic capture_compare_one_event,
  input wire logic capture_compare_two_event,
  input wire logic pulse_width_three_output,
  input wire logic pulse_width_four_output,
  input wire logic pin_change_flag,
  output logic analog_on_o,
  output logic hold_o,
  output logic [5:0] chan_sel_o,
  output logic chan_valid_o,
  output logic [1:0] ref_sel_o,
  output logic ref_valid_o,
  output logic irq_o
);
  logic [5:0] input_channel_select_q;
  logic on_q;
  logic go_q;
  logic go_d;
  logic result_alignment_q;
  logic [2:0] clk_sel_q;
  logic [1:0] positive_reference_select_q;
  logic [3:0] trigger_source_select_q;
  logic [15:0] result_q;
  logic [7:0] irq_status_q;
  logic [7:0] irq_mask_q;
  adcc_pkg::adcc_state_e state_q;
  logic [7:0] tad_cnt_q;
  logic [8:0] src_prev_q;
  logic [8:0] src_now;
  logic req;
  logic [9:0] idx;
  logic wr;
  logic rd;
  logic sw_start;
  logic sw_stop;
  logic high_read;
  logic trig_edge;
  logic tick;
  logic done;
  logic [7:0] divisor;
  logic [31:0] rd_data;

  // a new request is one not yet answered, so ack is exactly one cycle
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign idx = wb_adr_i[11:2];
  assign wr = req && wb_we_i;
  assign rd = req && !wb_we_i;
  assign high_read = rd && wb_sel_i[1] && idx == adcc_pkg::IDX_RESULT;

  // software go writes from the low byte of control 0
  // a go that clears the enable in the same write is dropped, not pulsed
  assign sw_start = wr && wb_sel_i[0] && idx == adcc_pkg::IDX_CTRL0
    && wb_dat_i[adcc_pkg::CTRL0_GO_BIT]
    && wb_dat_i[adcc_pkg::CTRL0_ON_BIT];
  assign sw_stop = wr && wb_sel_i[0] && idx == adcc_pkg::IDX_CTRL0
    && !wb_dat_i[adcc_pkg::CTRL0_GO_BIT];

  // trigger sources packed in code order, code one in bit zero
  assign src_now = {pin_change_flag, pulse_width_four_output,
    pulse_width_three_output, capture_compare_two_event,
    capture_compare_one_event, timer_two_divided_output,
    timer_one_rollover, timer_zero_rollover, trig_pin_remap};

  // edge of the selected source; reserved codes pick nothing
  always_comb begin
    trig_edge = 1'b0;
    if (trigger_source_select_q != adcc_pkg::TRIG_NONE
        && trigger_source_select_q <= adcc_pkg::TRIG_LAST_SOURCE) begin
      trig_edge = src_now[trigger_source_select_q - 4'h1]
        && !src_prev_q[trigger_source_select_q - 4'h1];
    end else if (trigger_source_select_q == adcc_pkg::TRIG_HIGH_READ) begin
      trig_edge = high_read;
    end
  end

  // previous source levels for edge detection
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      src_prev_q <= 9'h000;
    end else begin
      src_prev_q <= src_now;
    end
  end

  // conversion clock divisor; rc codes fall back to a slow fixed divisor
  always_comb begin
    case (clk_sel_q)
      adcc_pkg::CLK_DIV2: divisor = 8'h02;
      adcc_pkg::CLK_DIV4: divisor = 8'h04;
      adcc_pkg::CLK_DIV8: divisor = 8'h08;
      adcc_pkg::CLK_DIV16: divisor = 8'h10;
      adcc_pkg::CLK_DIV32: divisor = 8'h20;
      adcc_pkg::CLK_DIV64: divisor = 8'h40;
      default: divisor = 8'(RC_DIV);
    endcase
  end

  adcc_tad_gen #(
    .CNT_W(8)
  ) u_tad (
    .clk_sys(clk_sys),
    .rst(rst),
    .run(state_q == adcc_pkg::ST_CONV),
    .divisor(divisor),
    .tick(tick)
  );

  assign done = state_q == adcc_pkg::ST_CONV && tick
    && tad_cnt_q == 8'(CONV_TADS - 1);

  // busy bit: completion and power-off clear, start needs the enable
  always_comb begin
    go_d = go_q;
    if (done || !on_q) begin
      go_d = 1'b0;
    end else if ((sw_start || trig_edge) && state_q == adcc_pkg::ST_IDLE) begin
      go_d = 1'b1;
    end else if (sw_stop) begin
      go_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      go_q <= 1'b0;
    end else begin
      go_q <= go_d;
    end
  end

  // conversion sequencer; clearing busy by hand aborts
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= adcc_pkg::ST_IDLE;
      tad_cnt_q <= 8'h00;
    end else begin
      case (state_q)
        adcc_pkg::ST_IDLE: begin
          tad_cnt_q <= 8'h00;
          if (go_q && on_q) begin
            state_q <= adcc_pkg::ST_CONV;
          end
        end
        adcc_pkg::ST_CONV: begin
          if (done || !go_q || !on_q) begin
            state_q <= adcc_pkg::ST_IDLE;
            tad_cnt_q <= 8'h00;
          end else if (tick) begin
            tad_cnt_q <= tad_cnt_q + 8'h01;
          end
        end
        default: begin
          state_q <= adcc_pkg::ST_IDLE;
          tad_cnt_q <= 8'h00;
        end
      endcase
    end
  end

  // control and trigger registers, low byte lane only
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      input_channel_select_q <= 6'h00;
      on_q <= 1'b0;
      result_alignment_q <= 1'b0;
      clk_sel_q <= 3'h0;
      positive_reference_select_q <= 2'h0;
      trigger_source_select_q <= 4'h0;
      irq_mask_q <= adcc_pkg::RST_BYTE;
    end else if (wr && wb_sel_i[0]) begin
      case (idx)
        adcc_pkg::IDX_CTRL0: begin
          input_channel_select_q <=
            wb_dat_i[adcc_pkg::CTRL0_CHAN_LSB +: 6];
          on_q <= wb_dat_i[adcc_pkg::CTRL0_ON_BIT];
        end
        adcc_pkg::IDX_CTRL1: begin
          result_alignment_q <= wb_dat_i[adcc_pkg::CTRL1_ALIGN_BIT];
          clk_sel_q <= wb_dat_i[adcc_pkg::CTRL1_CLK_LSB +: 3];
          positive_reference_select_q <=
            wb_dat_i[adcc_pkg::CTRL1_REF_LSB +: 2];
        end
        adcc_pkg::IDX_TRIG: trigger_source_select_q <= wb_dat_i[3:0];
        adcc_pkg::IDX_IRQ_MASK: irq_mask_q <= wb_dat_i[7:0];
        default: begin
        end
      endcase
    end
  end

  // result: completion load wins over a software byte write that same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      result_q <= adcc_pkg::RST_RESULT;
    end else if (done) begin
      if (result_alignment_q) begin
        result_q <= {{adcc_pkg::RESULT_PAD{1'b0}}, conv_data_i};
      end else begin
        result_q <= {conv_data_i, {adcc_pkg::RESULT_PAD{1'b0}}};
      end
    end else if (wr && idx == adcc_pkg::IDX_RESULT) begin
      // stored raw, alignment is not applied to writes
      if (wb_sel_i[0]) begin
        result_q[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        result_q[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // done flag is sticky; a read clears it but a new completion wins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_status_q <= adcc_pkg::RST_BYTE;
    end else begin
      if (rd && wb_sel_i[0] && idx == adcc_pkg::IDX_IRQ_STATUS) begin
        irq_status_q <= adcc_pkg::RST_BYTE;
      end
      if (done) begin
        irq_status_q[adcc_pkg::IRQ_DONE_BIT] <= 1'b1;
      end
    end
  end

  // read mux; unmapped words answer zero
  always_comb begin
    rd_data = 32'h0000_0000;
    case (idx)
      adcc_pkg::IDX_RESULT: rd_data = {16'h0000, result_q};
      adcc_pkg::IDX_CTRL0: rd_data = {24'h000000, input_channel_select_q,
        go_q, on_q};
      adcc_pkg::IDX_CTRL1: rd_data = {24'h000000, result_alignment_q,
        clk_sel_q, 2'h0, positive_reference_select_q};
      adcc_pkg::IDX_TRIG: rd_data = {28'h0000000, trigger_source_select_q};
      adcc_pkg::IDX_IRQ_STATUS: rd_data = {24'h000000, irq_status_q};
      adcc_pkg::IDX_IRQ_MASK: rd_data = {24'h000000, irq_mask_q};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // bus answer registered: ack one cycle after the request
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= rd ? rd_data : 32'h0000_0000;
    end
  end

  // analog side controls; hold only tracks the conversion, never discharges
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      analog_on_o <= 1'b0;
      hold_o <= 1'b0;
      chan_sel_o <= 6'h00;
      chan_valid_o <= 1'b0;
      ref_sel_o <= 2'h0;
      ref_valid_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      analog_on_o <= on_q;
      hold_o <= on_q && state_q == adcc_pkg::ST_CONV;
      chan_sel_o <= input_channel_select_q;
      chan_valid_o <= on_q && (input_channel_select_q <= 6'h02
        || input_channel_select_q == 6'h04 || input_channel_select_q == 6'h05
        || (input_channel_select_q >= 6'h0d && input_channel_select_q <= 6'h0f)
        || (input_channel_select_q >= 6'h12 && input_channel_select_q <= 6'h15)
        || input_channel_select_q == adcc_pkg::CHAN_GROUND
        || input_channel_select_q == adcc_pkg::CHAN_FIXED_REF);
      ref_sel_o <= positive_reference_select_q;
      ref_valid_o <= on_q
        && positive_reference_select_q != adcc_pkg::REF_RESERVED;
      irq_o <= |(irq_status_q & irq_mask_q);
    end
  end

  a_start_sets_busy: assert property (@(posedge clk_sys) disable iff (rst)
    sw_start && on_q && state_q == adcc_pkg::ST_IDLE |=> go_q ##1
    state_q == adcc_pkg::ST_CONV) else $error("start did not set busy");
  a_done_clears_busy: assert property (@(posedge clk_sys) disable iff (rst)
    done |=> !go_q && state_q == adcc_pkg::ST_IDLE)
    else $error("busy not cleared at end");
  a_done_sets_flag: assert property (@(posedge clk_sys) disable iff (rst)
    done |=> irq_status_q[adcc_pkg::IRQ_DONE_BIT] ##1
    irq_o == $past(irq_mask_q[0]))
    else $error("done flag not set");
  a_right_align_load: assert property (@(posedge clk_sys) disable iff (rst)
    done && result_alignment_q |=> result_q == {6'h00, $past(conv_data_i)})
    else $error("right aligned result wrong");
  a_left_align_load: assert property (@(posedge clk_sys) disable iff (rst)
    done && !result_alignment_q |=> result_q[5:0] == 6'h00
    && result_q[15:6] == $past(conv_data_i))
    else $error("left aligned result wrong");
  a_off_stays_idle: assert property (@(posedge clk_sys) disable iff (rst)
    !on_q |=> !go_q && !analog_on_o && !hold_o && !chan_valid_o
    && !ref_valid_o)
    else $error("converter active while off");
  a_trig_edge_starts: assert property (@(posedge clk_sys) disable iff (rst)
    trig_edge && on_q && state_q == adcc_pkg::ST_IDLE && !sw_stop |=> go_q)
    else $error("trigger edge missed");
  a_high_read_trig: assert property (@(posedge clk_sys) disable iff (rst)
    trigger_source_select_q == adcc_pkg::TRIG_HIGH_READ && high_read
    && on_q && state_q == adcc_pkg::ST_IDLE |=> go_q)
    else $error("high byte read did not trigger");
  a_reserved_chan: assert property (@(posedge clk_sys) disable iff (rst)
    input_channel_select_q == 6'h03 |=> !chan_valid_o)
    else $error("reserved channel drives input");
  a_ack_single: assert property (@(posedge clk_sys) disable iff (rst)
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
endmodule : adcc_ctrl

// File: design/adcc_pkg.sv
// shared constants for the converter control register block
package adcc_pkg;
  // word indices; byte address is four times the index
  localparam logic [9:0] IDX_RESULT = 10'h09b;
  localparam logic [9:0] IDX_CTRL0 = 10'h09d;
  localparam logic [9:0] IDX_CTRL1 = 10'h09e;
  localparam logic [9:0] IDX_TRIG = 10'h09f;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h0a0;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h0a1;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_RESULT = 16'h0000;
  // control register 0 fields
  localparam int CTRL0_ON_BIT = 0;
  localparam int CTRL0_GO_BIT = 1;
  localparam int CTRL0_CHAN_LSB = 2;
  // control register 1 fields
  localparam int CTRL1_REF_LSB = 0;
  localparam int CTRL1_CLK_LSB = 4;
  localparam int CTRL1_ALIGN_BIT = 7;
  // interrupt status bit for conversion done
  localparam int IRQ_DONE_BIT = 0;
  // channel codes that reach a real input
  localparam logic [5:0] CHAN_GROUND = 6'h1b;
  localparam logic [5:0] CHAN_FIXED_REF = 6'h1e;
  // positive reference codes
  localparam logic [1:0] REF_RESERVED = 2'h1;
  // conversion clock codes
  localparam logic [2:0] CLK_DIV2 = 3'h0;
  localparam logic [2:0] CLK_DIV8 = 3'h1;
  localparam logic [2:0] CLK_DIV32 = 3'h2;
  localparam logic [2:0] CLK_DIV4 = 3'h4;
  localparam logic [2:0] CLK_DIV16 = 3'h5;
  localparam logic [2:0] CLK_DIV64 = 3'h6;
  // trigger codes
  localparam logic [3:0] TRIG_NONE = 4'h0;
  localparam logic [3:0] TRIG_LAST_SOURCE = 4'h9;
  localparam logic [3:0] TRIG_HIGH_READ = 4'hd;
  localparam int TRIG_SOURCES = 9;
  // result geometry
  localparam int RESULT_BITS = 10;
  localparam int RESULT_PAD = 6;
  // conversion state machine
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } adcc_state_e;
endpackage : adcc_pkg

// File: design/adcc_tad_gen.sv
// conversion clock period tick generator
`timescale 1ns/10ps
module adcc_tad_gen #(
  parameter int CNT_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic run,
  input wire logic [CNT_W-1:0] divisor,
  output logic tick
);
  logic [CNT_W-1:0] cnt_q;

  // free count only while running, so each conversion starts phase aligned
  always_ff @(posedge clk_sys) begin
    if (rst || !run) begin
      cnt_q <= '0;
    end else if (cnt_q >= divisor - CNT_W'(1)) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  assign tick = run && (cnt_q >= divisor - CNT_W'(1));
endmodule : adcc_tad_gen
